// ===== design/spi_port_regs.svh
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets, word aligned
// ----------------------------------------------------------------------
`define REG_CTRL      6'h00
`define REG_BAUD      6'h04
`define REG_CLK_SEL   6'h08
`define REG_TCOUNT    6'h0C
`define REG_TWIDTH    6'h10
`define REG_FLAGS     6'h14
`define REG_ENABLES   6'h18
`define REG_STATUS    6'h1C
`define REG_TX_PORT   6'h20
`define REG_RX_PORT   6'h24

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_CLEAR_BIT 8
`define EVT_TCZ        0
`define EVT_RD_ERR     1
`define EVT_WR_ERR     2
`define EVT_RX_OVF     3
`define ENA_TX_EVT     4
`define ENA_RX_EVT     5

// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define CTRL_RESET     8'h00
`define BAUD_RESET     8'h00
`define CLK_SEL_RESET  2'h0
`define TWIDTH_RESET   3'h0
`define FLAGS_RESET    4'h0
`define ENABLES_RESET  6'h00
`define FULL_WIDTH     4'h8
`define FIFO_AW        1
`define FIFO_DEPTH     2

`endif

// ===== design/spi_port_pkg.sv
package spi_port_pkg;

  // control register layout, bit 0 is the module enable
  typedef struct packed {
    logic clock_phase;
    logic clock_polarity;
    logic count_mode_select;
    logic receive_request_enable;
    logic transmit_request_enable;
    logic lsb_first_select;
    logic host_mode;
    logic enable;
  } ctrl_t;

  // serial pins seen from outside the clock domain
  typedef struct packed {
    logic sck;
    logic sdi;
    logic select_n;
  } pins_in_t;

  // serial pins driven by the port
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
    logic select_n;
  } pins_out_t;

  // host sequencer states
  typedef enum logic {st_idle, st_run} host_state_t;

endpackage

// ===== design/spi_host_client_port.sv
// Behaviour
// - empty transmit fifo resends previous received word
// - serial output also routed to internal path
// - one bit per clock, msb or lsb first
// - separate transmit and receive fifos
// - launch on one edge, sample opposite
// - host drives clock, shared phase and polarity
// - send leading bit, shift in at lsb, or at msb when lsb first
// - completed word written to receive fifo
// - reload next word and continue
// - dummy transmit and receive discard controls
// - segments of one to eight bits
// - host stops clock and deselects when done
// - unselected client ignores lines, drives nothing
// - one select line per client
// - host bit clock from selectable baud generator
// - byte mode counts bytes of given width
// - bit mode joins count and width
// - receive only starts on count write
// - transmit starts on fifo write, counter decrements
// - summary flag from enabled module events
// - separate transmit and receive event flags
// - status shows state and fifo fill
// - disable aborts, blocks flags, empties fifos
// - empty receive read gives zero, error flag
// - full transmit write dropped, error flag
// - busy high during transfer
`timescale 1ns/100ps
`include "spi_port_regs.svh"

module spi_host_client_port (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic [5:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  input  wire spi_port_pkg::pins_in_t  pins_in,
  output spi_port_pkg::pins_out_t      pins_out,
  output logic                         serial_out_internal,
  output logic                         summary_event_flag,
  output logic                         transmit_event_flag,
  output logic                         receive_event_flag
);
  import spi_port_pkg::*;

  localparam int AW = `FIFO_AW;
  localparam int CW = AW + 1;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // next occupancy of a fifo
  function automatic logic [CW-1:0] next_count(input logic [CW-1:0] c,
                                               input logic push,
                                               input logic pop);
    next_count = c + CW'(push) - CW'(pop);
  endfunction

  // bit that goes on the line next
  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction

  // shift the outgoing register by one place
  function automatic logic [7:0] shift_out(input logic [7:0] v,
                                           input logic lsb);
    shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  // mask of the low w bits
  function automatic logic [7:0] low_mask(input logic [3:0] w);
    low_mask = 8'((9'h001 << w) - 9'h001);
  endfunction

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  ctrl_t              ctrl;        // control word
  logic [7:0]         baud;        // baud_divider
  logic [1:0]         clk_sel;     // bit_clock_source_select
  logic [18:0]        left;        // live transfer_count with width bits
  logic [2:0]         tw;          // transfer_width
  logic [3:0]         flags;       // module_event_flags
  logic [5:0]         enables;     // module_event_enables
  logic               rd_err;      // fifo was empty when read was prepared
  logic               go_rx;       // receive only start request
  logic [7:0]         tx_mem [`FIFO_DEPTH];
  logic [7:0]         rx_mem [`FIFO_DEPTH];
  logic [AW-1:0]      tx_wp, tx_rp, rx_wp, rx_rp;
  logic [CW-1:0]      tx_cnt, rx_cnt;
  pins_in_t           s1, s2;      // input synchroniser stages
  logic               sck_prev;    // previous synced clock active level
  logic               sel_prev;    // previous synced select
  host_state_t        st;          // host sequencer
  logic               half;        // clock in active half
  logic               sck_q, sck_oe_q, sdo_q, sdo_oe_q, sel_n_q;
  logic [2:0]         pre;         // source prescaler
  logic [7:0]         div;         // baud divider counter
  logic [7:0]         txs, rxs, last_rx;
  logic [3:0]         nbits;       // bits sampled in this word
  logic [3:0]         w;           // width of this word
  logic               skip;        // suppress one launch after reload
  logic               counted;     // transfer is under counter control

  // ----------------------------------------------------------------------
  // decode and selection
  // ----------------------------------------------------------------------
  wire        en        = ctrl.enable;
  wire        host      = ctrl.host_mode;
  wire        lsb_first = ctrl.lsb_first_select;
  wire        tx_req    = ctrl.transmit_request_enable;
  wire        rx_req    = ctrl.receive_request_enable;
  wire        byte_mode = ctrl.count_mode_select;
  wire        cpha      = ctrl.clock_phase;
  wire        cpol      = ctrl.clock_polarity;
  wire        req       = read | write;
  wire        prep      = req & waitrequest;
  wire        take      = req & ~waitrequest;
  wire [31:0] wd        = writedata;
  wire        wr_ctrl   = take & write & (address == `REG_CTRL);
  wire        wr_baud   = take & write & (address == `REG_BAUD);
  wire        wr_csel   = take & write & (address == `REG_CLK_SEL);
  wire        wr_tcnt   = take & write & (address == `REG_TCOUNT);
  wire        wr_twid   = take & write & (address == `REG_TWIDTH);
  wire        wr_flag   = take & write & (address == `REG_FLAGS);
  wire        wr_enab   = take & write & (address == `REG_ENABLES);
  wire        wr_txp    = take & write & (address == `REG_TX_PORT);
  wire        rd_rxp    = take & read & (address == `REG_RX_PORT);
  wire        clr       = wr_ctrl & wd[`CTRL_CLEAR_BIT];
  wire        flush     = ~en | clr;
  wire        tx_empty  = tx_cnt == '0;
  wire        tx_full   = tx_cnt == CW'(`FIFO_DEPTH);
  wire        rx_empty  = rx_cnt == '0;
  wire        rx_full   = rx_cnt == CW'(`FIFO_DEPTH);
  wire        run       = st == st_run;
  wire        sel_act   = ~s2.select_n;
  wire        busy      = host ? run : (en & sel_act);
  wire [7:0]  rx_head   = rx_empty ? 8'h00 : rx_mem[rx_rp];
  wire [15:0] tcnt_view = byte_mode ? left[15:0] : left[18:3];
  wire [7:0]  status    = {receive_event_flag, transmit_event_flag,
                           summary_event_flag, busy, rx_full, rx_empty,
                           tx_full, tx_empty};

  // read data selection, unmapped offsets read zero
  wire [31:0] rd_mux =
    (address == `REG_CTRL)    ? 32'(ctrl)      :
    (address == `REG_BAUD)    ? 32'(baud)      :
    (address == `REG_CLK_SEL) ? 32'(clk_sel)   :
    (address == `REG_TCOUNT)  ? 32'(tcnt_view) :
    (address == `REG_TWIDTH)  ? 32'(tw)        :
    (address == `REG_FLAGS)   ? 32'(flags)     :
    (address == `REG_ENABLES) ? 32'(enables)   :
    (address == `REG_STATUS)  ? 32'(status)    :
    (address == `REG_RX_PORT) ? 32'(rx_head)   : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // baud generator and edge events
  // ----------------------------------------------------------------------
  wire [2:0] pmask = (clk_sel == 2'h0) ? 3'h0 :
                     (clk_sel == 2'h1) ? 3'h1 :
                     (clk_sel == 2'h2) ? 3'h3 : 3'h7;
  wire src_tick   = (pre & pmask) == pmask;
  wire half_tick  = host & run & src_tick & (div == baud);
  wire host_lead  = en & half_tick & ~half;
  wire host_trail = en & half_tick & half;
  wire sck_act    = s2.sck ^ cpol;
  wire cl_on      = ~host & en & sel_act;
  wire cl_lead    = cl_on & sck_act & ~sck_prev;
  wire cl_trail   = cl_on & ~sck_act & sck_prev;
  wire lead       = host_lead | cl_lead;
  wire trail      = host_trail | cl_trail;
  wire sample     = cpha ? trail : lead;
  wire launch     = cpha ? lead : trail;
  wire sel_rise   = cl_on & ~sel_prev;

  // ----------------------------------------------------------------------
  // word sequencing
  // ----------------------------------------------------------------------
  wire [3:0] nb_after = nbits + 4'(sample);
  wire word_end = nb_after == w;
  wire done     = host ? (trail & word_end)
                       : (cl_on & sample & word_end);
  wire more     = counted ? (left != '0) : (tx_req & ~tx_empty);
  wire host_go  = host & en & ~run &
                  ((tx_req & ~tx_empty) | go_rx);
  wire h_load   = host_go | (host & done & more);
  wire c_load   = sel_rise | (cl_on & done);
  wire load     = h_load | c_load;
  wire cnt_now  = (host_go | sel_rise) ? (left != '0) : counted;
  wire [3:0] tw8 = (tw == 3'h0) ? `FULL_WIDTH : {1'b0, tw};
  wire [3:0] seg = (cnt_now & ~byte_mode) ?
                   ((|left[18:3]) ? `FULL_WIDTH : {1'b0, left[2:0]}) :
                   tw8;
  wire tx_pop    = load & tx_req & ~tx_empty;
  wire [7:0] next_rxs = lsb_first ? {s2.sdi, rxs[7:1]}
                                  : {rxs[6:0], s2.sdi};
  // a word may end on an edge that does not sample (phase 0 host)
  wire [7:0] rx_src   = sample ? next_rxs : rxs;
  wire [7:0] rx_word  = lsb_first ? (rx_src >> (`FULL_WIDTH - w))
                                  : (rx_src & low_mask(w));
  wire [7:0] tx_word = (tx_req & ~tx_empty) ? tx_mem[tx_rp] :
                       ~tx_req ? 8'h00 :
                       done ? rx_word : last_rx;
  wire [7:0] ld_val  = lsb_first ? tx_word
                                 : 8'(tx_word << (`FULL_WIDTH - seg));
  wire rx_push  = done & rx_req & ~rx_full;
  wire tx_push  = wr_txp & ~tx_full;
  wire rx_pop   = rd_rxp & ~rd_err;
  wire [3:0] set_f;
  assign set_f[`EVT_TCZ]    = done & counted & (left == '0);
  assign set_f[`EVT_RD_ERR] = rd_rxp & rd_err;
  assign set_f[`EVT_WR_ERR] = wr_txp & tx_full;
  assign set_f[`EVT_RX_OVF] = done & rx_req & rx_full;

  // ----------------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------------
  assign pins_out = '{sck: sck_q, sck_oe: sck_oe_q, sdo: sdo_q,
                      sdo_oe: sdo_oe_q, select_n: sel_n_q};
  assign serial_out_internal = sdo_q;

  // ----------------------------------------------------------------------
  // bus slave: one wait cycle, answer on the second
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      rd_err      <= 1'b0;
    end else begin
      waitrequest <= ~prep;
      if (prep & read) begin
        readdata <= rd_mux;
        rd_err   <= rx_empty;
      end
    end
  end

  // control and configuration; control bits other than enable, baud and clock select lock while enabled, width locks while busy, event enables never lock
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl    <= ctrl_t'(`CTRL_RESET);
      baud    <= `BAUD_RESET;
      clk_sel <= `CLK_SEL_RESET;
      tw      <= `TWIDTH_RESET;
      enables <= `ENABLES_RESET;
    end else begin
      if (wr_ctrl & en)
        ctrl.enable <= wd[0];
      else if (wr_ctrl)
        ctrl <= ctrl_t'(wd[7:0]);
      if (wr_baud & ~en)
        baud <= wd[7:0];
      if (wr_csel & ~en)
        clk_sel <= wd[1:0];
      if (wr_twid & ~busy)
        tw <= wd[2:0];
      if (wr_enab)
        enables <= wd[5:0];
    end
  end

  // event flags: write one to clear, a new event wins over its clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      flags <= `FLAGS_RESET;
    else
      flags <= (flags & ~({4{wr_flag}} & wd[3:0]))
               | (set_f & {4{en}});
  end

  // summary and fifo event outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      summary_event_flag  <= 1'b0;
      transmit_event_flag <= 1'b0;
      receive_event_flag  <= 1'b0;
    end else begin
      summary_event_flag  <= |(flags & enables[3:0]);
      transmit_event_flag <= enables[`ENA_TX_EVT] & ~tx_full;
      receive_event_flag  <= enables[`ENA_RX_EVT] & ~rx_empty;
    end
  end

  // ----------------------------------------------------------------------
  // fifos
  // ----------------------------------------------------------------------
  // data storage, written on push only
  always_ff @(posedge clock) begin
    if (tx_push)
      tx_mem[tx_wp] <= wd[7:0];
    if (rx_push)
      rx_mem[rx_wp] <= rx_word;
  end

  // transmit pointers and occupancy
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end else if (flush) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wp  <= tx_wp + AW'(tx_push);
      tx_rp  <= tx_rp + AW'(tx_pop);
      tx_cnt <= next_count(tx_cnt, tx_push, tx_pop);
    end
  end

  // receive pointers and occupancy
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end else if (flush) begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end else begin
      rx_wp  <= rx_wp + AW'(rx_push);
      rx_rp  <= rx_rp + AW'(rx_pop);
      rx_cnt <= next_count(rx_cnt, rx_push, rx_pop);
    end
  end

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  // two stages before any logic looks at the pins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1       <= 3'b001;
      s2       <= 3'b001;
      sck_prev <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      s1       <= pins_in;
      s2       <= s1;
      sck_prev <= sck_act;
      sel_prev <= cl_on;
    end
  end

  // ----------------------------------------------------------------------
  // host clock generation
  // ----------------------------------------------------------------------
  // prescaler runs free, divider restarts each transfer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pre <= 3'h0;
      div <= 8'h00;
    end else begin
      pre <= pre + 3'h1;
      if (~run)
        div <= 8'h00;
      else if (src_tick)
        div <= (div == baud) ? 8'h00 : div + 8'h01;
    end
  end

  // sequencer, clock level and select output
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st       <= st_idle;
      half     <= 1'b0;
      sck_q    <= 1'b0;
      sck_oe_q <= 1'b0;
      sel_n_q  <= 1'b1;
      sdo_oe_q <= 1'b0;
    end else if (~en) begin
      st       <= st_idle;
      half     <= 1'b0;
      sck_q    <= cpol;
      sck_oe_q <= 1'b0;
      sel_n_q  <= 1'b1;
      sdo_oe_q <= 1'b0;
    end else begin
      if (host_go)
        st <= st_run;
      else if (host & done & ~more)
        st <= st_idle;
      if (host_lead) begin
        half  <= 1'b1;
        sck_q <= ~cpol;
      end else if (host_trail) begin
        half  <= 1'b0;
        sck_q <= cpol;
      end else if (~run) begin
        half  <= 1'b0;
        sck_q <= cpol;
      end
      sck_oe_q <= host;
      sel_n_q  <= ~host | (~run & ~host_go)
                  | (done & ~more);
      sdo_oe_q <= tx_req & (host | sel_act);
    end
  end

  // ----------------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------------
  // outgoing word, bit count and line bit
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      txs   <= 8'h00;
      nbits <= 4'h0;
      w     <= `FULL_WIDTH;
      sdo_q <= 1'b0;
      skip  <= 1'b0;
    end else if (~en | (~host & ~sel_act)) begin
      nbits <= 4'h0;
      skip  <= 1'b0;
    end else if (load) begin
      w     <= seg;
      nbits <= 4'h0;
      skip  <= ~host & ~cpha & done;
      if (~cpha) begin
        sdo_q <= out_bit(ld_val, lsb_first);
        txs   <= shift_out(ld_val, lsb_first);
      end else begin
        txs <= ld_val;
      end
    end else begin
      if (sample)
        nbits <= nb_after;
      if (launch)
        skip <= 1'b0;
      if (launch & ~skip) begin
        sdo_q <= out_bit(txs, lsb_first);
        txs   <= shift_out(txs, lsb_first);
      end
    end
  end

  // incoming shift register and last received word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rxs     <= 8'h00;
      last_rx <= 8'h00;
    end else begin
      if (sample)
        rxs <= next_rxs;
      if (done)
        last_rx <= rx_word;
    end
  end

  // transfer counter: loaded by software, counted down per word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      left    <= 19'h0_0000;
      counted <= 1'b0;
      go_rx   <= 1'b0;
    end else begin
      go_rx <= host & wr_tcnt & ~busy & ~tx_req & rx_req
               & (|wd[15:0]);
      if (host_go | sel_rise)
        counted <= left != '0;
      if (wr_tcnt & ~busy)
        left <= byte_mode ? 19'(wd[15:0])
                          : {wd[15:0], left[2:0]};
      else if (wr_twid & ~busy & ~byte_mode)
        left[2:0] <= wd[2:0];
      else if (load & cnt_now)
        left <= byte_mode ? left - 19'h0_0001
                          : left - 19'(seg);
    end
  end

endmodule

// ===== verif/spi_port_sva.sv
`timescale 1ns/100ps
// watches the port pins and the register bus of the serial port
module spi_port_sva
  import spi_port_pkg::*;
(
  input wire logic             clock,
  input wire logic             reset,
  input wire logic [5:0]       address,
  input wire logic             read,
  input wire logic             write,
  input wire logic [31:0]      writedata,
  input wire logic [31:0]      readdata,
  input wire logic             waitrequest,
  input wire spi_port_pkg::pins_in_t  pins_in,
  input wire spi_port_pkg::pins_out_t pins_out,
  input wire logic             serial_out_internal,
  input wire logic             summary_event_flag,
  input wire logic             transmit_event_flag,
  input wire logic             receive_event_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // a request still waiting for its answer
  sequence access_s;
    (read || write) && waitrequest;
  endsequence
  one_wait_a: assert property (access_s |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not exactly one cycle");
  answer_cause_a: assert property ($fell(waitrequest) |-> $past(read||write))
    else $error("bus answer without a request");
  rdata_hold_a: assert property ($changed(readdata) |-> !waitrequest && read)
    else $error("read data moved outside a read answer");
  out_route_a: assert property (serial_out_internal == pins_out.sdo)
    else $error("internal serial route differs from pin");
  sck_framed_a: assert property ($changed(pins_out.sck) && pins_out.sck_oe
    && $past(pins_out.sck_oe, 2) |-> !$past(pins_out.select_n))
    else $error("host clock moved while deselected");
  select_lead_a: assert property ($fell(pins_out.select_n)
    |-> $stable(pins_out.sck))
    else $error("clock edge together with select");
  client_quiet_a: assert property ((!pins_out.sck_oe && pins_in.select_n)[*4]
    |-> !pins_out.sdo_oe)
    else $error("unselected client drives data");
  reset_idle_a: assert property ($fell(reset) |-> waitrequest
    && pins_out.select_n && !pins_out.sck_oe)
    else $error("outputs not idle after reset");
endmodule

bind spi_host_client_port spi_port_sva u_sva (.clock(clock), .reset(reset),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .pins_in(pins_in),
  .pins_out(pins_out), .serial_out_internal(serial_out_internal),
  .summary_event_flag(summary_event_flag),
  .transmit_event_flag(transmit_event_flag),
  .receive_event_flag(receive_event_flag));

// ===== verif/spi_client_model.sv
`timescale 1ns/100ps
// far client, mode 0: samples on rising clock, launches on falling
module spi_client_model (
  input wire logic       sck,
  input wire logic       select_n,
  input wire logic       mosi,
  input wire logic [7:0] load,
  output logic           miso = 1'b0,
  output logic [7:0]     got
);
  logic [7:0] shift;  // outgoing word
  always @(negedge select_n) begin
    shift = load;
    miso = load[7];
  end
  always @(posedge sck) if (!select_n) got = {got[6:0], mosi};
  always @(negedge sck) if (!select_n) begin
    shift = {shift[6:0], 1'b0};
    miso = shift[7];
  end
  // released line shows no stale bit
  always @(posedge select_n) miso = ~miso;
endmodule

// ===== verif/spi_host_client_port_bench.sv
`timescale 1ns/100ps
`include "spi_port_regs.svh"
`define check(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module spi_host_client_port_bench;
  import spi_port_pkg::*;
  logic clock = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, q;
  logic [31:0] seed = 32'h0000_d668;
  logic [7:0] load = 8'h00, got, sent;
  logic miso, sum_f, txe_f, rxe_f;
  logic c_sck = 1'b0, c_sdi = 1'b0, c_sel_n = 1'b1, client = 1'b0;
  logic [7:0] heard;
  pins_in_t pins_in;
  pins_out_t pins_out;
  int failures = 0, tests_run = 0, i;
  assign pins_in = '{sck: c_sck, sdi: client ? c_sdi : miso,
                     select_n: c_sel_n};
  spi_host_client_port u_dut (.clock(clock), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pins_in(pins_in), .pins_out(pins_out),
    .serial_out_internal(), .summary_event_flag(sum_f),
    .transmit_event_flag(txe_f), .receive_event_flag(rxe_f));
  spi_client_model u_far (.sck(pins_out.sck), .select_n(pins_out.select_n),
    .mosi(pins_out.sdo), .load(load), .miso(miso), .got(got));
  initial forever #5 clock = ~clock;
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7-k];
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one register access, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one byte each way through the far client
  task automatic xfer(input logic [7:0] b, input logic lsb);
    seed = lfsr(seed);
    load = seed[15:8];
    sent = b;
    bus(0, `REG_TX_PORT, {24'h0, sent});
    bus(1, `REG_STATUS, 0);
    `check(q[4], 1'b1)
    do bus(1, `REG_STATUS, 0); while (q[4] !== 1'b0);
    bus(1, `REG_RX_PORT, 0);
    `check(q[7:0], lsb ? rev8(load) : load)
    `check(got, lsb ? rev8(sent) : sent)
  endtask
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    bus(1, `REG_STATUS, 0);
    `check(q[7:0], 8'h05)
    bus(1, 6'h3C, 0);
    `check(q, 32'h0000_0000)
    bus(0, `REG_BAUD, 3);
    bus(0, `REG_CLK_SEL, 1);
    for (i = 0; i < 2; i++) begin
      bus(0, `REG_CTRL, 0);
      bus(0, `REG_CTRL, {27'h0, 2'b11, i[0], 2'b11});
      xfer(8'h80, i[0]);
      xfer(8'h01, i[0]);
      repeat (3) begin
        seed = lfsr(seed);
        xfer(seed[23:16], i[0]);
      end
    end
    // client mode: the bench plays the far host, phase 0, msb first
    bus(0, `REG_CTRL, 0);
    bus(0, `REG_CTRL, 32'h0000_0019);
    seed = lfsr(seed);
    {load, sent} = seed[15:0];
    bus(0, `REG_TX_PORT, {24'h0, sent});
    `check(pins_out.sdo_oe, 1'b0)
    client  <= 1'b1;
    c_sel_n <= 1'b0;
    for (i = 7; i >= 0; i--) begin
      c_sdi <= load[i];
      repeat (4) @(posedge clock);
      heard = {heard[6:0], pins_out.sdo};
      c_sck <= 1'b1;
      repeat (4) @(posedge clock);
      c_sck <= 1'b0;
    end
    repeat (4) @(posedge clock);
    `check(pins_out.sdo_oe, 1'b1)
    c_sel_n <= 1'b1;
    repeat (4) @(posedge clock);
    `check(pins_out.sdo_oe, 1'b0)
    `check(heard, sent)
    bus(1, `REG_RX_PORT, 0);
    `check(q[7:0], load)
    bus(1, `REG_RX_PORT, 0);
    `check(q, 32'h0000_0000)
    bus(1, `REG_FLAGS, 0);
    `check(q[1], 1'b1)
    bus(0, `REG_ENABLES, 32'h0000_0032);
    bus(1, `REG_STATUS, 0);
    `check(q[7:0], 8'h65)
    `check({rxe_f, txe_f, sum_f}, 3'b011)
    bus(0, `REG_FLAGS, 32'h0000_000F);
    bus(1, `REG_FLAGS, 0);
    `check(q[1], 1'b0)
    `check(sum_f, 1'b0)
    repeat (4) bus(0, `REG_TX_PORT, 32'h0000_00A5);
    bus(1, `REG_FLAGS, 0);
    `check(q[2], 1'b1)
    bus(0, `REG_CTRL, 0);
    repeat (2) @(posedge clock);
    bus(1, `REG_STATUS, 0);
    `check(q[7:0], 8'h45)
    tally_and_finish;
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    tally_and_finish;
  end
endmodule
